// File: verif/acp_host.sv
// host controller model driving select, read/convert and the sample
`timescale 1ns/1ps
module acp_host
    import acp_pkg::*;
(
    input wire logic clk_in,
    output logic cs_n_out,
    output logic rc_out,
    output acp_word_t sample_out
);
    initial begin
        cs_n_out = 1'b1;
        rc_out = 1'b1;
        sample_out = 12'h000;
    end
    task automatic drive(input logic cs_n, input logic rc, input acp_word_t smp, input int n);
        @(posedge clk_in);
        #2;
        cs_n_out = cs_n;
        rc_out = rc;
        sample_out = smp;
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // one pin goes low first, the other falls last; both then stay low 50 ns or more
    task automatic start(input logic cs_last, input acp_word_t smp);
        drive(cs_last, !cs_last, smp, 3);
        drive(1'b0, 1'b0, smp, 2);
    endtask
endmodule // acp_host

// File: verif/acp_port_asserts.sv
// pin-level assertion checker for the conversion port
`timescale 1ns/1ps
module acp_port_asserts
    import acp_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic cs_n_in,
    input wire logic rc_in,
    input wire acp_word_t sample_in,
    input wire logic busy_n_out,
    input wire acp_word_t result_bits_out,
    input wire logic result_oe_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    wire comb_n = cs_n_in | rc_in;
    // busy stays low for 48 conversion cycles plus the push and load steps
    sequence s_conv; ##49 !busy_n_out; endsequence
    sequence s_done; ##1 busy_n_out; endsequence
    sequence s_read; (!cs_n_in && rc_in)[*4]; endsequence
    property p_hiz_busy; !busy_n_out |-> !result_oe_out; endproperty
    property p_hiz_pins; (cs_n_in || !rc_in)[*4] |-> !result_oe_out; endproperty
    property p_start; busy_n_out && $fell(comb_n) |-> ##[1:5] !busy_n_out; endproperty
    property p_len; $fell(busy_n_out) |-> s_conv ##0 s_done; endproperty
    property p_ignore; (!comb_n)[*4] ##0 $rose(busy_n_out) |=> busy_n_out[*4]; endproperty
    property p_read; (busy_n_out && !cs_n_in && rc_in)[*4] |-> result_oe_out; endproperty
    property p_latch; s_read ##0 $rose(busy_n_out) |-> result_oe_out; endproperty
    property p_hold; $changed(result_bits_out) |-> !$past(result_oe_out); endproperty
    a_hiz_busy: assert property (p_hiz_busy) else $error("bus on while busy");
    a_hiz_pins: assert property (p_hiz_pins) else $error("bus on while deselected");
    a_start: assert property (p_start) else $error("no start");
    a_len: assert property (p_len) else $error("busy length wrong");
    a_ignore: assert property (p_ignore) else $error("start not ignored");
    a_read: assert property (p_read) else $error("bus not enabled");
    a_latch: assert property (p_latch) else $error("no data at busy rise");
    a_hold: assert property (p_hold) else $error("data moved while driven");
endmodule // acp_port_asserts

bind acp_port acp_port_asserts u_chk (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .cs_n_in(cs_n_in),
    .rc_in(rc_in),
    .sample_in(sample_in),
    .busy_n_out(busy_n_out),
    .result_bits_out(result_bits_out),
    .result_oe_out(result_oe_out)
);

// File: verif/tb_adc_parallel_conversion_port.sv
// self-checking testbench for the conversion port
`timescale 1ns/1ps
module tb_adc_parallel_conversion_port;
    import acp_pkg::*;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic cs_n, rc, busy_n, oe;
    acp_word_t samp, res;
    int num_errors = 0;
    int n_checks = 0;
    acp_host host (.clk_in(clk_in), .cs_n_out(cs_n), .rc_out(rc), .sample_out(samp));
    acp_port DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n), .rc_in(rc),
        .sample_in(samp), .busy_n_out(busy_n), .result_bits_out(res), .result_oe_out(oe));
    initial begin
        forever #12.5 clk_in = ~clk_in;
    end
    function automatic acp_word_t w(input logic b);
        return {11'h000, b};
    endfunction
    task automatic chk(input acp_word_t seen, input acp_word_t exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wait_busy(input logic lvl);
        for (int i = 0; i < 100 && busy_n !== lvl; i++) begin
            @(posedge clk_in);
            #1;
        end
        chk(w(busy_n), w(lvl));
    endtask
    task automatic end_sim;
        if (num_errors == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic t_rc_read;
        host.start(1'b0, 12'h7FF);
        wait_busy(1'b0);
        host.drive(1'b0, 1'b1, 12'h000, 2);
        chk(w(oe), 12'h000);
        wait_busy(1'b1);
        chk(w(oe), 12'h001);
        chk(res, 12'h7FF);
    endtask
    task automatic t_cs_read;
        host.start(1'b1, 12'h800);
        wait_busy(1'b0);
        host.drive(1'b1, 1'b0, 12'h000, 2);
        wait_busy(1'b1);
        host.drive(1'b1, 1'b1, 12'h000, 4);
        chk(w(oe), 12'h000);
        host.drive(1'b0, 1'b1, 12'h000, 4);
        chk(w(oe), 12'h001);
        chk(res, 12'h800);
    endtask
    task automatic t_ignore;
        host.start(1'b0, 12'h123);
        wait_busy(1'b0);
        host.drive(1'b0, 1'b1, 12'h456, 3);
        host.drive(1'b0, 1'b0, 12'h456, 3);
        wait_busy(1'b1);
        host.drive(1'b0, 1'b1, 12'h456, 4);
        chk(w(busy_n), 12'h001);
        chk(res, 12'h123);
        chk(w(oe), 12'h001);
    endtask
    initial begin
        #100us;
        num_errors++;
        end_sim();
    end
    initial begin
        repeat (12) @(posedge clk_in);
        #2 rst_n_in = 1'b1;
        repeat (4) @(posedge clk_in);
        #1;
        chk(w(busy_n), 12'h001);
        chk(w(oe), 12'h000);
        t_rc_read();
        t_cs_read();
        t_ignore();
        end_sim();
    end
endmodule // tb_adc_parallel_conversion_port

// File: verilog/acp_buf.sv
// two-entry result buffer with valid and ready on both sides
`timescale 1ns/1ps

module acp_buf
    import acp_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    acp_stream_if.snk fill,
    acp_stream_if.src drain
);

    acp_buf_st_t st_r;
    acp_buf_st_t st_nxt;
    logic do_push;
    logic do_pop;

    assign fill.ready = (st_r.count != 2'h2);
    assign drain.valid = (st_r.count != 2'h0);
    assign drain.data = st_r.rd_ptr ? st_r.data1 : st_r.data0;
    assign do_push = fill.valid && fill.ready;
    assign do_pop = drain.valid && drain.ready;

    always_comb begin
        st_nxt = st_r;
        if (do_push) begin
            if (st_r.wr_ptr) begin
                st_nxt.data1 = fill.data;
            end else begin
                st_nxt.data0 = fill.data;
            end
            st_nxt.wr_ptr = ~st_r.wr_ptr;
        end
        if (do_pop) begin
            st_nxt.rd_ptr = ~st_r.rd_ptr;
        end
        if (do_push && !do_pop) begin
            st_nxt.count = st_r.count + 2'h1;
        end else if (do_pop && !do_push) begin
            st_nxt.count = st_r.count - 2'h1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule // acp_buf

// File: verilog/acp_defines.svh
// constants for the parallel conversion port
`ifndef ACP_DEFINES_SVH
`define ACP_DEFINES_SVH

`define ACP_DATA_W 12
`define ACP_TOP_BIT 11
`define ACP_BOTTOM_BIT 0
`define ACP_CLK_NS 25
`define ACP_START_NS 40
`define ACP_START_CYC ((`ACP_START_NS) / (`ACP_CLK_NS))
`define ACP_CONV_CYC 48
`define ACP_CNT_W 8
`define ACP_BUF_DEPTH 2
`define ACP_RESULT_RST 12'h000

`endif

// File: verilog/acp_pkg.sv
// types shared by the parallel conversion port
`include "acp_defines.svh"

package acp_pkg;

    typedef logic [`ACP_DATA_W-1:0] acp_word_t;
    typedef logic [`ACP_CNT_W-1:0] acp_cnt_t;

    // gray codes along idle -> convert -> push -> load -> idle
    typedef enum logic [1:0] {
        ACP_IDLE = 2'h0,
        ACP_CONV = 2'h1,
        ACP_PUSH = 2'h3,
        ACP_LOAD = 2'h2
    } acp_state_t;

    typedef struct packed {
        logic [1:0] cs_n_sync;
        logic [1:0] rc_sync;
        acp_word_t samp_s1;
        acp_word_t samp_s2;
        acp_cnt_t low_cnt;
        acp_state_t state;
        acp_cnt_t conv_cnt;
        acp_word_t hold;
        logic busy_n;
        logic oe;
        acp_word_t result;
    } acp_port_st_t;

    typedef struct packed {
        acp_word_t data0;
        acp_word_t data1;
        logic [1:0] count;
        logic rd_ptr;
        logic wr_ptr;
    } acp_buf_st_t;

endpackage

// File: verilog/acp_port.sv
// control and readout port of a 12-bit sampling converter
//
// Function
// - result bus undriven when select high, read/convert low, or converting
// - select low: read/convert falling edge holds the sample and starts conversion
// - select low, idle: read/convert rising edge drives stored result
// - read/convert low: select falling edge starts a conversion
// - read/convert high, idle: select falling edge enables stored result
// - busy low from start until result captured in output register
// - with select low and read high, data valid when busy rises
// - result is one 12-bit word, bit 11 most significant, bit 0 least
// - results are two's complement, sign on the top bit
// - start requests during busy low are ignored
// - controls combine as active-low levels, either may fall last
`timescale 1ns/1ps
`include "acp_defines.svh"

module acp_port
    import acp_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic cs_n_in,
    input wire logic rc_in,
    input wire logic [`ACP_DATA_W-1:0] sample_in,
    output logic busy_n_out,
    output logic [`ACP_DATA_W-1:0] result_bits_out,
    output logic result_oe_out
);

    localparam acp_cnt_t START_CYC = acp_cnt_t'(`ACP_START_CYC);
    localparam acp_cnt_t START_NEED = (START_CYC == '0) ? acp_cnt_t'(1) : START_CYC;
    localparam acp_cnt_t CONV_LAST = acp_cnt_t'(`ACP_CONV_CYC - 1);

    logic [1:0] rst_sync_r;
    logic rst_n;

    acp_port_st_t st_r;
    acp_port_st_t st_nxt;

    acp_stream_if to_buf ();
    acp_stream_if from_buf ();

    logic cs_n_s;
    logic rc_s;
    logic start_lvl;
    logic start_fire;
    logic read_lvl;

    // reset released through two flops
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_r[1];

    acp_buf u_buf (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .fill(to_buf.snk),
        .drain(from_buf.src)
    );

    // second sync stages only are read by logic
    assign cs_n_s = st_r.cs_n_sync[1];
    assign rc_s = st_r.rc_sync[1];

    // both controls low together, in either order
    assign start_lvl = !cs_n_s && !rc_s;
    assign read_lvl = !cs_n_s && rc_s;

    // start fires once the combined low has lasted the qualifying samples
    assign start_fire = start_lvl && (st_r.low_cnt == START_NEED - acp_cnt_t'(1));

    assign to_buf.valid = (st_r.state == ACP_PUSH);
    assign to_buf.data = st_r.hold;
    // output register stays put while the bus shows it
    assign from_buf.ready = (st_r.state == ACP_LOAD) && !st_r.oe;

    always_comb begin
        st_nxt = st_r;
        st_nxt.cs_n_sync = {st_r.cs_n_sync[0], cs_n_in};
        st_nxt.rc_sync = {st_r.rc_sync[0], rc_in};
        st_nxt.samp_s1 = sample_in;
        st_nxt.samp_s2 = st_r.samp_s1;

        if (!start_lvl) begin
            st_nxt.low_cnt = '0;
        end else if (st_r.low_cnt != START_NEED) begin
            st_nxt.low_cnt = st_r.low_cnt + acp_cnt_t'(1);
        end

        case (st_r.state)
            ACP_IDLE: begin
                if (start_fire) begin
                    // sampler to hold: freeze the two's complement code
                    st_nxt.hold = st_r.samp_s2;
                    st_nxt.conv_cnt = '0;
                    st_nxt.busy_n = 1'b0;
                    st_nxt.state = ACP_CONV;
                end
            end
            ACP_CONV: begin
                // requests here are ignored
                if (st_r.conv_cnt == CONV_LAST) begin
                    st_nxt.state = ACP_PUSH;
                end else begin
                    st_nxt.conv_cnt = st_r.conv_cnt + acp_cnt_t'(1);
                end
            end
            ACP_PUSH: begin
                if (to_buf.ready) begin
                    st_nxt.state = ACP_LOAD;
                end
            end
            ACP_LOAD: begin
                if (from_buf.valid && from_buf.ready) begin
                    st_nxt.result = from_buf.data;
                    st_nxt.busy_n = 1'b1;
                    st_nxt.state = ACP_IDLE;
                end
            end
            default: begin
                st_nxt.state = ACP_IDLE;
            end
        endcase

        // drive only when selected, in read, and no conversion
        st_nxt.oe = read_lvl && (st_nxt.state == ACP_IDLE);
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.cs_n_sync <= 2'h3;
            st_r.rc_sync <= 2'h3;
            st_r.state <= ACP_IDLE;
            st_r.busy_n <= 1'b1;
            st_r.result <= `ACP_RESULT_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign busy_n_out = st_r.busy_n;
    assign result_bits_out = st_r.result;
    assign result_oe_out = st_r.oe;

endmodule // acp_port

// File: verilog/acp_stream_if.sv
// valid/ready word stream between the port and its buffer
`timescale 1ns/1ps

interface acp_stream_if;
    import acp_pkg::*;
    logic valid;
    logic ready;
    acp_word_t data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
